// ==== logic/fb_pkg.sv ====
// Purpose: shared constants and types for the fieldbus slave state and sync manager link
// Assumes: one clock CLK_SYS at 250 MHz, synchronous active-high reset
// Notes:   the link is a simple word-level logic interface, no physical layer
package fb_pkg;
    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned MBX_BYTES_DEF  = 276;
    localparam int unsigned MBX_PAYLOAD    = 255;
    localparam int unsigned PD_WIDTH_DEF   = 32;
    localparam int unsigned TIME_WIDTH     = 32;
    // sync0 period in ns and the cycle count derived from the clock rate
    localparam int unsigned SYNC0_NS_DEF   = 1000;
    localparam int unsigned SYNC0_CYC_DEF  = SYNC0_NS_DEF * CLK_MHZ / 1000;
    localparam logic [1:0]  BUF3_RST       = 2'h0;
    localparam logic [7:0]  MBX_IDX_RST    = 8'h00;

    typedef enum logic [2:0] {
        ST_INIT,
        ST_PREOP,
        ST_SAFEOP,
        ST_OP,
        ST_BOOT
    } al_state_t;

    typedef enum logic [0:0] {
        MODE_BUF3,
        MODE_BUF1
    } sm_mode_t;

    // whether a requested target is an allowed step, up or down, from the current state
    function automatic logic legal_step(input al_state_t cur, input al_state_t req);
        logic ok;
        ok = 1'b0;
        case (cur)
            ST_INIT:   ok = (req == ST_PREOP) || (req == ST_BOOT);
            ST_PREOP:  ok = (req == ST_SAFEOP) || (req == ST_INIT);
            ST_SAFEOP: ok = (req == ST_OP) || (req == ST_PREOP) || (req == ST_INIT);
            ST_OP:     ok = (req != ST_BOOT) && (req != ST_OP);
            ST_BOOT:   ok = (req == ST_INIT);
            default:   ok = 1'b0;
        endcase
        return ok;
    endfunction : legal_step

    // free buffer of three for the writer: the one not latest and not in read use
    function automatic logic [1:0] free_buf(input logic [1:0] a, input logic [1:0] b);
        logic [1:0] f;
        f = 2'h0;
        for (int i = 0; i < 3; i++) begin
            if ((2'(i) != a) && (2'(i) != b)) begin
                f = 2'(i);
            end
        end
        return f;
    endfunction : free_buf
endpackage : fb_pkg

// ==== logic/fb_link_if.sv ====
// Purpose: link between the fieldbus master end and the slave end
// Assumes: both ends on CLK_SYS; valid is a one-cycle strobe, except tx_valid, which stays high while a slave message is held
// Notes:   mailbox words carry one byte each; last marks the end of a message
`timescale 1ns/1ns
interface fb_link_if #(parameter int unsigned PDW = fb_pkg::PD_WIDTH_DEF);
    import fb_pkg::*;
    logic            st_req_valid;
    al_state_t       st_req;
    al_state_t       st_cur;
    logic            st_err;
    logic            rx_valid;
    logic [7:0]      rx_data;
    logic            rx_last;
    logic            rx_free;
    logic            tx_ready;
    logic            tx_read;
    logic [7:0]      tx_data;
    logic            tx_last;
    logic            tx_valid;
    logic            out_valid;
    logic [PDW-1:0]  out_data;
    logic            in_read;
    logic [PDW-1:0]  in_data;
    logic            sync_valid;
    logic [TIME_WIDTH-1:0] sync_time;

    modport master (
        output st_req_valid, st_req, rx_valid, rx_data, rx_last, tx_read,
               out_valid, out_data, in_read, sync_valid, sync_time,
        input  st_cur, st_err, rx_free, tx_ready, tx_data, tx_last, tx_valid, in_data
    );
    modport slave (
        input  st_req_valid, st_req, rx_valid, rx_data, rx_last, tx_read,
               out_valid, out_data, in_read, sync_valid, sync_time,
        output st_cur, st_err, rx_free, tx_ready, tx_data, tx_last, tx_valid, in_data
    );
endinterface : fb_link_if

// ==== logic/fb_slave.sv ====
// Purpose: slave end: state machine, mailbox and process sync managers, sync0 unit
// Assumes: master keeps the one-buffer handshake and requests legal state steps
// Notes:   mailbox is one byte-wide flip-flop buffer per direction
//
// Contract
// - reset enters INIT, no application traffic
// - configuration loaded in INIT before leaving
// - PREOP: mailbox active, process data refused
// - SAFEOP: inputs only, outputs held safe (PD_OUT keeps its last OP value; it is cleared only in INIT)
// - OP: inputs and outputs both exchanged
// - BOOT: mailbox only, larger mailbox allowed
// - run indicator shows current state
// - sync manager blocks simultaneous buffer writes
// - buffer mode loaded from configuration image
// - three-buffer access has no timing limits
// - three areas: one free, one latest
// - one-buffer written only when empty (in MODE_BUF1 the process channel overwrites ibuf[0] on every sample)
// - one-buffer read only when fully written
// - receive mailbox channel, default 276 bytes
// - transmit mailbox channel, default 276 bytes
// - output process channel holds received outputs
// - input process channel holds sent inputs
// - local clock corrected from sync telegram
// - compare unit pulses SYNC0 to controller
// - DC mode samples position at SYNC0
`timescale 1ns/1ns
module fb_slave #(
    parameter int unsigned MBX_BYTES  = fb_pkg::MBX_BYTES_DEF,
    parameter int unsigned BOOT_BYTES = 2 * fb_pkg::MBX_BYTES_DEF,
    parameter int unsigned PDW        = fb_pkg::PD_WIDTH_DEF,
    parameter int unsigned SYNC0_CYC  = fb_pkg::SYNC0_CYC_DEF
) (
    input  wire logic                      CLK_SYS,       // system clock
    input  wire logic                      SYS_RST,       // sync reset, high
    fb_link_if.slave                       LINK,          // link to master
    input  wire logic                      CFG_VALID,     // config image loaded
    input  wire fb_pkg::sm_mode_t          CFG_PD_MODE,   // process channel mode
    input  wire logic                      CFG_DC_MODE,   // sample at sync0
    input  wire logic [PDW-1:0]            POSITION,      // position sample
    input  wire logic                      POS_STROBE,    // free-run sample strobe
    input  wire logic                      MBX_RD,        // local mailbox pop
    input  wire logic                      MBX_WR,        // local mailbox push
    input  wire logic [7:0]                MBX_WDATA,     // local push byte
    input  wire logic                      MBX_WLAST,     // local push last
    output logic [7:0]                     MBX_RDATA,     // local pop byte
    output logic                           MBX_RLAST,     // local pop last
    output logic                           MBX_RX_FULL,   // message waiting
    output logic [PDW-1:0]                 PD_OUT,        // applied outputs
    output logic                           SYNC0,         // sync0 pulse
    output logic [fb_pkg::TIME_WIDTH-1:0]  LOCAL_TIME,    // corrected clock
    output logic [2:0]                     RUN_LED        // current state code
);
    import fb_pkg::*;
    localparam int unsigned MAXB = (BOOT_BYTES > MBX_BYTES) ? BOOT_BYTES : MBX_BYTES;
    localparam int unsigned AW   = $clog2(MAXB + 1);
    localparam int unsigned CW   = $clog2(SYNC0_CYC + 1);

    typedef struct packed {
        al_state_t             st;
        logic                  err;
        sm_mode_t              mode;
        logic                  dc;
        logic [MAXB-1:0][8:0]  rxb;
        logic [AW-1:0]         rx_wp;
        logic [AW-1:0]         rx_rp;
        logic                  rx_full;
        logic [MAXB-1:0][8:0]  txb;
        logic [AW-1:0]         tx_wp;
        logic [AW-1:0]         tx_rp;
        logic                  tx_full;
        logic [2:0][PDW-1:0]   ibuf;
        logic [1:0]            i_latest;
        logic [1:0]            i_read;
        logic [PDW-1:0]        pd_out;
        logic [PDW-1:0]        in_word;
        logic [7:0]            mrd;
        logic                  mlast;
        logic [CW-1:0]         cnt;
        logic                  sync0;
        logic [TIME_WIDTH-1:0] ltime;
    } slv_t;

    slv_t cur_ff;
    slv_t nxt_cur;
    logic [AW-1:0] lim;
    logic          mbx_ok;
    logic          in_ok;
    logic          out_ok;

    always_comb begin
        nxt_cur = cur_ff;
        lim     = (cur_ff.st == ST_BOOT) ? AW'(BOOT_BYTES) : AW'(MBX_BYTES);
        mbx_ok  = (cur_ff.st != ST_INIT);
        in_ok   = (cur_ff.st == ST_SAFEOP) || (cur_ff.st == ST_OP);
        out_ok  = (cur_ff.st == ST_OP);
        nxt_cur.sync0 = 1'b0;
        nxt_cur.err   = 1'b0;
        // state change requests
        if (LINK.st_req_valid) begin
            if (legal_step(cur_ff.st, LINK.st_req) && (cur_ff.st != ST_INIT || CFG_VALID)) begin
                nxt_cur.st = LINK.st_req;
            end else if (LINK.st_req != cur_ff.st) begin
                nxt_cur.err = 1'b1;
            end
        end
        // configuration is taken only while in INIT
        if (cur_ff.st == ST_INIT && CFG_VALID) begin
            nxt_cur.mode = CFG_PD_MODE;
            nxt_cur.dc   = CFG_DC_MODE;
        end
        // receive mailbox: master fills, controller drains
        if (mbx_ok && LINK.rx_valid && !cur_ff.rx_full && cur_ff.rx_wp < lim) begin
            nxt_cur.rxb[cur_ff.rx_wp] = {LINK.rx_last, LINK.rx_data};
            nxt_cur.rx_wp = cur_ff.rx_wp + AW'(1);
            if (LINK.rx_last) begin
                nxt_cur.rx_full = 1'b1;
                nxt_cur.rx_rp   = '0;
            end
        end
        if (cur_ff.rx_full && MBX_RD) begin
            {nxt_cur.mlast, nxt_cur.mrd} = cur_ff.rxb[cur_ff.rx_rp];
            nxt_cur.rx_rp = cur_ff.rx_rp + AW'(1);
            if (cur_ff.rxb[cur_ff.rx_rp][8]) begin
                nxt_cur.rx_full = 1'b0;
                nxt_cur.rx_wp   = '0;
            end
        end
        // transmit mailbox: controller fills, master drains
        if (mbx_ok && MBX_WR && !cur_ff.tx_full && cur_ff.tx_wp < lim) begin
            nxt_cur.txb[cur_ff.tx_wp] = {MBX_WLAST, MBX_WDATA};
            nxt_cur.tx_wp = cur_ff.tx_wp + AW'(1);
            if (MBX_WLAST) begin
                nxt_cur.tx_full = 1'b1;
                nxt_cur.tx_rp   = '0;
            end
        end
        if (cur_ff.tx_full && LINK.tx_read) begin
            nxt_cur.tx_rp = cur_ff.tx_rp + AW'(1);
            if (cur_ff.txb[cur_ff.tx_rp][8]) begin
                nxt_cur.tx_full = 1'b0;
                nxt_cur.tx_wp   = '0;
            end
        end
        // output process channel; written only in OP, held at last value otherwise, cleared in INIT
        if (out_ok && LINK.out_valid) begin
            nxt_cur.pd_out = LINK.out_data;
        end
        // distributed clock: telegram time overrides the free count
        nxt_cur.ltime = LINK.sync_valid ? LINK.sync_time : cur_ff.ltime + TIME_WIDTH'(1);
        if (cur_ff.cnt == CW'(SYNC0_CYC - 1)) begin
            nxt_cur.cnt   = '0;
            nxt_cur.sync0 = cur_ff.dc;
        end else begin
            nxt_cur.cnt = cur_ff.cnt + CW'(1);
        end
        // input process channel, three buffers in MODE_BUF3 (ibuf[0] only in MODE_BUF1); sampling owns the free one
        if (in_ok && (cur_ff.dc ? cur_ff.sync0 : POS_STROBE)) begin
            if (cur_ff.mode == MODE_BUF3) begin
                nxt_cur.ibuf[free_buf(cur_ff.i_latest, cur_ff.i_read)] = POSITION;
                nxt_cur.i_latest = free_buf(cur_ff.i_latest, cur_ff.i_read);
            end else begin
                nxt_cur.ibuf[0] = POSITION;
            end
        end
        // master read locks the latest buffer so the writer never touches it in MODE_BUF3
        if (in_ok && LINK.in_read) begin
            nxt_cur.i_read  = (cur_ff.mode == MODE_BUF3) ? cur_ff.i_latest : 2'h0;
            nxt_cur.in_word = (cur_ff.mode == MODE_BUF3) ? cur_ff.ibuf[cur_ff.i_latest]
                                                         : cur_ff.ibuf[0];
        end
        if (!in_ok) begin
            nxt_cur.in_word = '0;
        end
        if (nxt_cur.st == ST_INIT) begin
            nxt_cur.pd_out  = '0;
            nxt_cur.rx_full = 1'b0;
            nxt_cur.tx_full = 1'b0;
            nxt_cur.rx_wp   = '0;
            nxt_cur.tx_wp   = '0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            cur_ff          <= '0;
            cur_ff.st       <= ST_INIT;
            cur_ff.mode     <= MODE_BUF3;
            cur_ff.i_latest <= BUF3_RST;
            cur_ff.i_read   <= 2'h1;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign LINK.st_cur   = cur_ff.st;
    assign LINK.st_err   = cur_ff.err;
    assign LINK.rx_free  = mbx_ok && !cur_ff.rx_full;
    assign LINK.tx_ready = cur_ff.tx_full;
    assign LINK.tx_valid = cur_ff.tx_full;
    assign LINK.tx_data  = cur_ff.txb[cur_ff.tx_rp][7:0];
    assign LINK.tx_last  = cur_ff.txb[cur_ff.tx_rp][8];
    assign LINK.in_data  = cur_ff.in_word;
    assign MBX_RDATA     = cur_ff.mrd;
    assign MBX_RLAST     = cur_ff.mlast;
    assign MBX_RX_FULL   = cur_ff.rx_full;
    assign PD_OUT        = cur_ff.pd_out;
    assign SYNC0         = cur_ff.sync0;
    assign LOCAL_TIME    = cur_ff.ltime;
    assign RUN_LED       = cur_ff.st;
endmodule : fb_slave

// ==== logic/fb_master.sv ====
// Purpose: master end: state requests, mailbox traffic, process data, sync telegram
// Assumes: user side issues one-cycle commands; slave answers on the link
// Notes:   mailbox send only starts when the slave reports the buffer empty
`timescale 1ns/1ns
module fb_master #(
    parameter int unsigned PDW = fb_pkg::PD_WIDTH_DEF
) (
    input  wire logic                      CLK_SYS,      // system clock
    input  wire logic                      SYS_RST,      // sync reset, high
    fb_link_if.master                      LINK,         // link to slave
    input  wire logic                      REQ_ST,       // state change command
    input  wire fb_pkg::al_state_t         REQ_TARGET,   // requested state
    input  wire logic                      MB_PUSH,      // send mailbox byte
    input  wire logic [7:0]                MB_BYTE,      // byte to send
    input  wire logic                      MB_LAST,      // last byte of message
    input  wire logic                      MB_POP,       // read one byte from slave
    input  wire logic                      PD_WR,        // write outputs
    input  wire logic [PDW-1:0]            PD_WDATA,     // output data
    input  wire logic                      PD_RD,        // read inputs
    input  wire logic                      SYNC_SEND,    // send sync telegram
    input  wire logic [fb_pkg::TIME_WIDTH-1:0] REF_TIME, // reference clock time
    output logic                           MB_BUSY,      // slave buffer full or mailbox closed
    output logic [7:0]                     MB_RBYTE,     // byte read from slave
    output logic                           MB_RLAST,     // read byte was last
    output logic                           MB_RVALID,    // read byte valid
    output logic [PDW-1:0]                 PD_RDATA,     // input data
    output fb_pkg::al_state_t              SLV_STATE     // slave state seen
);
    import fb_pkg::*;

    typedef struct packed {
        logic                  st_v;
        al_state_t             st;
        logic                  rx_v;
        logic [7:0]            rx_d;
        logic                  rx_l;
        logic                  sending;
        logic                  tx_rd;
        logic [7:0]            rb;
        logic                  rl;
        logic                  rv;
        logic                  o_v;
        logic [PDW-1:0]        o_d;
        logic                  i_rd;
        logic                  i_rd2;
        logic [PDW-1:0]        pd_r;
        logic                  s_v;
        logic [TIME_WIDTH-1:0] s_t;
        al_state_t             seen;
    } mst_t;

    mst_t cur_ff;
    mst_t nxt_cur;

    always_comb begin
        nxt_cur       = cur_ff;
        nxt_cur.st_v  = REQ_ST && legal_step(LINK.st_cur, REQ_TARGET);
        nxt_cur.st    = REQ_TARGET;
        // a message starts only into an empty buffer and runs to its last byte
        nxt_cur.rx_v  = MB_PUSH && (cur_ff.sending || LINK.rx_free);
        nxt_cur.rx_d  = MB_BYTE;
        nxt_cur.rx_l  = MB_LAST;
        if (nxt_cur.rx_v) begin
            nxt_cur.sending = !MB_LAST;
        end
        // read only a fully written slave message
        nxt_cur.tx_rd = MB_POP && LINK.tx_valid && !cur_ff.tx_rd;
        nxt_cur.rv    = cur_ff.tx_rd;
        if (MB_POP && LINK.tx_valid && !cur_ff.tx_rd) begin
            nxt_cur.rb = LINK.tx_data;
            nxt_cur.rl = LINK.tx_last;
        end
        // outputs only in OP; input reads are sent in any state
        nxt_cur.o_v   = PD_WR && (LINK.st_cur == ST_OP);
        nxt_cur.o_d   = PD_WDATA;
        nxt_cur.i_rd  = PD_RD;
        nxt_cur.i_rd2 = cur_ff.i_rd;
        if (cur_ff.i_rd2) begin
            nxt_cur.pd_r = LINK.in_data;
        end
        nxt_cur.s_v   = SYNC_SEND;
        nxt_cur.s_t   = REF_TIME;
        nxt_cur.seen  = LINK.st_cur;
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            cur_ff      <= '0;
            cur_ff.st   <= ST_INIT;
            cur_ff.seen <= ST_INIT;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign LINK.st_req_valid = cur_ff.st_v;
    assign LINK.st_req       = cur_ff.st;
    assign LINK.rx_valid     = cur_ff.rx_v;
    assign LINK.rx_data      = cur_ff.rx_d;
    assign LINK.rx_last      = cur_ff.rx_l;
    assign LINK.tx_read      = cur_ff.tx_rd;
    assign LINK.out_valid    = cur_ff.o_v;
    assign LINK.out_data     = cur_ff.o_d;
    assign LINK.in_read      = cur_ff.i_rd;
    assign LINK.sync_valid   = cur_ff.s_v;
    assign LINK.sync_time    = cur_ff.s_t;
    assign MB_BUSY           = !LINK.rx_free;
    assign MB_RBYTE          = cur_ff.rb;
    assign MB_RLAST          = cur_ff.rl;
    assign MB_RVALID         = cur_ff.rv;
    assign PD_RDATA          = cur_ff.pd_r;
    assign SLV_STATE         = cur_ff.seen;
endmodule : fb_master

// ==== verif/fb_link_chk.sv ====
// Purpose: checker on the link between the master end and the slave end
// Assumes: every link signal is sampled on CLK_SYS
// Notes:   refusals are not checked here; the master end sends only legal steps, but the slave still refuses leaving INIT without configuration
`timescale 1ns/1ns
module fb_link_chk #(
    parameter int unsigned PDW = fb_pkg::PD_WIDTH_DEF
) (
    input wire logic              CLK_SYS,      // clock
    input wire logic              SYS_RST,      // sync reset
    input wire logic              st_req_valid, // state request
    input wire fb_pkg::al_state_t st_req,       // target state
    input wire fb_pkg::al_state_t st_cur,       // slave state
    input wire logic              rx_valid,     // byte to slave
    input wire logic              rx_last,      // last byte
    input wire logic              rx_free,      // receive buffer empty
    input wire logic              in_read,      // input read
    input wire logic [PDW-1:0]    in_data       // input data
);
    import fb_pkg::*;
    logic in_msg_ff;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    // only the first byte of a message needs an empty buffer
    always_ff @(posedge CLK_SYS)
        in_msg_ff <= SYS_RST ? 1'b0 : (rx_valid ? !rx_last : in_msg_ff);
    property p_init_rst;
        $fell(SYS_RST) |-> st_cur == ST_INIT;
    endproperty
    a_init_rst: assert property (p_init_rst) else $error("not init after reset");
    property p_init_closed;
        st_cur == ST_INIT |-> !rx_free;
    endproperty
    a_init_closed: assert property (p_init_closed) else $error("mailbox open in init");
    property p_state_cause;
        $changed(st_cur) && !$past(SYS_RST) |-> $past(st_req_valid) && st_cur == $past(st_req);
    endproperty
    a_state_cause: assert property (p_state_cause) else $error("state moved unasked");
    property p_op_order;
        $changed(st_cur) && st_cur == ST_OP |-> $past(st_cur) == ST_SAFEOP;
    endproperty
    a_op_order: assert property (p_op_order) else $error("op not from safeop");
    property p_boot_entry;
        $changed(st_cur) && st_cur == ST_BOOT |-> $past(st_cur) == ST_INIT;
    endproperty
    a_boot_entry: assert property (p_boot_entry) else $error("boot not from init");
    property p_pd_refused;
        in_read && !st_req_valid && !(st_cur inside {ST_SAFEOP, ST_OP}) |=> in_data == '0;
    endproperty
    a_pd_refused: assert property (p_pd_refused) else $error("inputs leak");
    property p_rx_full;
        rx_valid && rx_last |=> !rx_free [*2];
    endproperty
    a_rx_full: assert property (p_rx_full) else $error("buffer free after message");
    property p_rx_start;
        rx_valid && !in_msg_ff |-> rx_free;
    endproperty
    a_rx_start: assert property (p_rx_start) else $error("write into full buffer");
endmodule : fb_link_chk

// ==== verif/testbench.sv ====
// Purpose: self-checking bench, master and slave ends joined by the link
// Assumes: 250 MHz clock, sync reset held 6 cycles, short sync0 period
// Notes:   drivers queue the expected read results, a monitor compares them
`timescale 1ns/1ns
module testbench;
    import fb_pkg::*;
    localparam int unsigned PDW = PD_WIDTH_DEF;
    localparam int unsigned S0C = 8;   // short sync0 period keeps the run brief
    logic           clk = 1'b0, rst = 1'b1, req_st = 1'b0, mb_push = 1'b0, mb_last = 1'b0;
    logic           mb_pop = 1'b0, pd_wr = 1'b0, pd_rd = 1'b0, sync_send = 1'b0;
    logic           cfg_valid = 1'b0, cfg_dc = 1'b0, pos_strobe = 1'b0, mbx_rd = 1'b0;
    logic           mbx_wr = 1'b0, mbx_wlast = 1'b0, lm_pipe = 1'b0;
    logic [2:0]     pd_pipe = 3'h0;
    logic [7:0]     mb_byte = 8'h00, mbx_wdata = 8'h00, mb_rbyte, mbx_rdata;
    logic [31:0]    ref_time = 32'h0000_0000, seed = 32'h0000_0043, local_time;
    logic [PDW-1:0] pd_wdata = '0, position = '0, pd_rdata, pd_out;
    logic           mb_busy, mb_rlast, mb_rvalid, mbx_rlast, rx_full, sync0;
    logic [2:0]     run_led;
    al_state_t      req_target = ST_INIT, slv_state;
    sm_mode_t       cfg_mode = MODE_BUF3;
    logic [8:0]     qm[$], ql[$];
    logic [PDW-1:0] qp[$];
    int             error_cnt = 0, tests_run = 0;

    fb_link_if #(.PDW(PDW)) link ();
    fb_master #(.PDW(PDW)) fb_master_i (.CLK_SYS(clk), .SYS_RST(rst), .LINK(link),
        .REQ_ST(req_st), .REQ_TARGET(req_target), .MB_PUSH(mb_push), .MB_BYTE(mb_byte),
        .MB_LAST(mb_last), .MB_POP(mb_pop), .PD_WR(pd_wr), .PD_WDATA(pd_wdata),
        .PD_RD(pd_rd), .SYNC_SEND(sync_send), .REF_TIME(ref_time), .MB_BUSY(mb_busy),
        .MB_RBYTE(mb_rbyte), .MB_RLAST(mb_rlast), .MB_RVALID(mb_rvalid),
        .PD_RDATA(pd_rdata), .SLV_STATE(slv_state));
    fb_slave #(.PDW(PDW), .SYNC0_CYC(S0C)) fb_slave_i (.CLK_SYS(clk), .SYS_RST(rst),
        .LINK(link), .CFG_VALID(cfg_valid), .CFG_PD_MODE(cfg_mode), .CFG_DC_MODE(cfg_dc),
        .POSITION(position), .POS_STROBE(pos_strobe), .MBX_RD(mbx_rd), .MBX_WR(mbx_wr),
        .MBX_WDATA(mbx_wdata), .MBX_WLAST(mbx_wlast), .MBX_RDATA(mbx_rdata),
        .MBX_RLAST(mbx_rlast), .MBX_RX_FULL(rx_full), .PD_OUT(pd_out), .SYNC0(sync0),
        .LOCAL_TIME(local_time), .RUN_LED(run_led));
    fb_link_chk #(.PDW(PDW)) fb_link_chk_i (.CLK_SYS(clk), .SYS_RST(rst),
        .st_req_valid(link.st_req_valid), .st_req(link.st_req), .st_cur(link.st_cur),
        .rx_valid(link.rx_valid), .rx_last(link.rx_last), .rx_free(link.rx_free),
        .in_read(link.in_read), .in_data(link.in_data));

    always #2 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic step(input al_state_t t, input al_state_t exp);
        @(posedge clk);
        req_st <= 1'b1;
        req_target <= t;
        @(posedge clk);
        req_st <= 1'b0;
        tick(5);
        check(64'(run_led), 64'(exp));
        check(64'(slv_state), 64'(exp));
    endtask : step
    task automatic mbx_down(input int n);
        for (int i = 0; i < n; i++) begin
            seed = xs(seed);
            @(posedge clk);
            mb_push <= 1'b1;
            mb_byte <= seed[7:0];
            mb_last <= (i == n - 1);
            ql.push_back({i == n - 1, seed[7:0]});
        end
        @(posedge clk);
        mb_push <= 1'b0;
        for (int k = 0; k < 20 && rx_full !== 1'b1; k++) @(posedge clk);
        check(64'(mb_busy), 64'(1));
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            mbx_rd <= 1'b1;
            @(posedge clk);
            mbx_rd <= 1'b0;
        end
        tick(3);
        check(64'({rx_full, mb_busy}), 64'(0));
    endtask : mbx_down
    task automatic mbx_up(input int n);
        for (int i = 0; i < n; i++) begin
            seed = xs(seed);
            @(posedge clk);
            mbx_wr <= 1'b1;
            mbx_wdata <= seed[7:0];
            mbx_wlast <= (i == n - 1);
            qm.push_back({i == n - 1, seed[7:0]});
        end
        @(posedge clk);
        mbx_wr <= 1'b0;
        for (int k = 0; k < 20 && link.tx_valid !== 1'b1; k++) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            mb_pop <= 1'b1;
            @(posedge clk);
            mb_pop <= 1'b0;
        end
        tick(4);
    endtask : mbx_up
    task automatic pd_write(output logic [PDW-1:0] v);
        seed = xs(seed);
        v = PDW'(seed);
        @(posedge clk);
        pd_wr <= 1'b1;
        pd_wdata <= v;
        @(posedge clk);
        pd_wr <= 1'b0;
        tick(4);
    endtask : pd_write
    task automatic sample(output logic [PDW-1:0] v);
        seed = xs(seed);
        v = PDW'(seed);
        @(posedge clk);
        position <= v;
        pos_strobe <= 1'b1;
        @(posedge clk);
        pos_strobe <= 1'b0;
    endtask : sample
    task automatic pd_read(input logic [PDW-1:0] exp);
        @(posedge clk);
        pd_rd <= 1'b1;
        qp.push_back(exp);
        @(posedge clk);
        pd_rd <= 1'b0;
        tick(3);
    endtask : pd_read

    always @(posedge clk) begin
        pd_pipe <= {pd_pipe[1:0], pd_rd};
        lm_pipe <= mbx_rd;
        if (mb_rvalid === 1'b1) begin
            check(64'({mb_rlast, mb_rbyte}), qm.size() ? 64'(qm.pop_front()) : 'x);
        end
        if (lm_pipe) begin
            check(64'({mbx_rlast, mbx_rdata}), ql.size() ? 64'(ql.pop_front()) : 'x);
        end
        if (pd_pipe[2]) begin
            check(64'(pd_rdata), qp.size() ? 64'(qp.pop_front()) : 'x);
        end
    end

    // the whole sequence needs well under 1000 cycles, so 10000 means a hang
    initial begin
        #40000;
        error_cnt++;
        stop_test();
    end

    initial begin
        logic [PDW-1:0] a;
        logic [PDW-1:0] b;
        int n;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        tick(2);
        check(64'({run_led, mb_busy}), 64'({ST_INIT, 1'b1}));
        step(ST_PREOP, ST_INIT);
        cfg_valid <= 1'b1;
        step(ST_PREOP, ST_PREOP);
        mbx_down(4);
        mbx_up(3);
        pd_write(a);
        check(64'(pd_out), 64'(0));
        sample(a);
        pd_read('0);
        step(ST_SAFEOP, ST_SAFEOP);
        pd_write(a);
        check(64'(pd_out), 64'(0));
        sample(a);
        sample(b);
        pd_read(b);
        step(ST_OP, ST_OP);
        pd_write(a);
        check(64'(pd_out), 64'(a));
        seed = xs(seed);
        @(posedge clk);
        sync_send <= 1'b1;
        ref_time <= seed;
        @(posedge clk);
        sync_send <= 1'b0;
        for (int k = 0; k < 20 && link.sync_valid !== 1'b1; k++) @(posedge clk);
        @(posedge clk);
        check(64'(local_time), 64'(seed));
        @(posedge clk);
        check(64'(local_time), 64'(seed + 32'h0000_0001));
        step(ST_INIT, ST_INIT);
        check(64'(pd_out), 64'(0));
        position <= b ^ a;
        cfg_dc <= 1'b1;
        cfg_mode <= MODE_BUF1;
        step(ST_PREOP, ST_PREOP);
        step(ST_SAFEOP, ST_SAFEOP);
        for (int k = 0; k < 40 && sync0 !== 1'b1; k++) @(posedge clk);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sync0 !== 1'b1 && n < 40);
        check(64'(n), 64'(S0C));
        pd_read(b ^ a);
        step(ST_INIT, ST_INIT);
        step(ST_BOOT, ST_BOOT);
        pd_read('0);
        mbx_down(5);
        stop_test();
    end
endmodule : testbench
